/* aru_entry_match.sv */
`timescale 1ns/100ps
module aru_entry_match
	import aru_pkg::*;
(
	// Candidate entry and current conditions
	input  wire logic [31:0] entry,
	input  wire logic [3:0]  gear,
	input  wire logic [15:0] modeSel,
	// Match result
	output logic             hit
);

	logic gearEq;
	logic modeEq;

	always_comb begin
		gearEq = (entry[ARU_F_GEAR_LSB +: 4] == gear);
		modeEq = |(entry[ARU_F_MASK_LSB +: 16] & modeSel);
		hit    = gearEq & modeEq;
	end

endmodule // aru_entry_match

/* aru_gear_src.sv */
`timescale 1ns/100ps
module aru_gear_src (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// Requested gear and mode
	input  wire logic [3:0]  reqGear,
	input  wire logic [15:0] reqMode,
	// Levels seen by the block
	output logic      [3:0]  dpcGear,
	output logic      [15:0] modeSel
);
	// Registered so a change lands one clean edge after the request
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dpcGear <= 4'h0;
			modeSel <= 16'h0000;
		end else begin
			dpcGear <= reqGear;
			modeSel <= reqMode;
		end
	end
endmodule // aru_gear_src

/* aru_pkg.sv */
package aru_pkg;

	// Table geometry
	localparam int          ARU_TABLE_DEPTH = 20;
	localparam logic [4:0]  ARU_DEPTH5      = 5'h14;
	localparam logic [7:0]  ARU_SIZE_IDX    = 8'h97;

	// Byte addresses on the bus
	localparam logic [11:0] ARU_TBL_BASE    = 12'h000;
	localparam logic [11:0] ARU_SIZE_ADDR   = {2'b00, ARU_SIZE_IDX, 2'b00};
	localparam logic [11:0] ARU_RXCTRL_ADDR = 12'h100;
	localparam logic [11:0] ARU_STATUS_ADDR = 12'h104;

	// Entry fields
	localparam int ARU_F_MASK_LSB = 16;
	localparam int ARU_F_MINP_LSB = 13;
	localparam int ARU_F_MIN_LSB  = 10;
	localparam int ARU_F_GAIN_LSB = 7;
	localparam int ARU_F_HPCF_LSB = 4;
	localparam int ARU_F_GEAR_LSB = 0;
	localparam int ARU_DELTA_W    = 3;

	// Size byte nibbles
	localparam int ARU_SZ_AWC_LSB = 0;
	localparam int ARU_SZ_ARC_LSB = 4;

	// Receiver control register fields
	localparam int ARU_RX_GAIN_LSB = 0;
	localparam int ARU_RECEIVER_HIGHPASS_CORNER_LSB = 4;
	localparam int ARU_RX_MIN_LSB  = 8;
	localparam int ARU_RX_MINP_LSB = 12;

	// Status register fields
	localparam int ARU_ST_BUSY_BIT = 0;
	localparam int ARU_ST_HIT_BIT  = 1;
	localparam int ARU_ST_IDX_LSB  = 8;
	localparam int ARU_ST_GEAR_LSB = 16;

	// Reset values
	localparam logic [7:0]  ARU_SIZE_RST  = 8'h00;
	localparam logic [31:0] ARU_ENTRY_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		ARU_IDLE  = 2'b00,
		ARU_SCAN  = 2'b01,
		ARU_APPLY = 2'b10
	} aru_state_t;

endpackage

/* aru_receiver_lut.sv */
`timescale 1ns/100ps
module aru_receiver_lut
	import aru_pkg::*;
#(
	parameter int GAIN_W  = 2,
	parameter int HPCF_W  = 2,
	parameter int LEVEL_W = 4
) (
	// Clock and reset
	input  wire logic               clock,
	input  wire logic               arst_n,
	// AHB-Lite slave
	input  wire logic               hsel,
	input  wire logic [31:0]        haddr,
	input  wire logic [1:0]         htrans,
	input  wire logic               hwrite,
	input  wire logic [2:0]         hsize,
	input  wire logic [31:0]        hwdata,
	input  wire logic               hready,
	output logic      [31:0]        hrdata,
	output logic                    hreadyout,
	output logic                    hresp,
	// Power gear and active technology/baud, same clock domain
	input  wire logic [3:0]         dpcGear,
	input  wire logic [15:0]        modeSel,
	// Receiver settings
	output logic      [GAIN_W-1:0]  rxGain,
	output logic      [HPCF_W-1:0]  rxHpcf,
	output logic      [LEVEL_W-1:0] minLevel,
	output logic      [LEVEL_W-1:0] minLevelP,
	output logic                    scanBusy
);

	aru_state_t         state;
	logic [31:0]        table_q [ARU_TABLE_DEPTH];
	logic [7:0]         tableSize;
	logic               dpValid;
	logic               dpWrite;
	logic [11:0]        dpAddr;
	logic [31:0]        rdMux;
	logic [3:0]         gearPrev;
	logic [15:0]        modePrev;
	logic               pending;
	logic               trigger;
	logic [4:0]         scanIdx;
	logic [4:0]         matchIdx;
	logic               lastHit;
	logic [3:0]         awcCount;
	logic [3:0]         arcCount;
	logic [4:0]         endIdx;
	logic [4:0]         scanLimit;
	logic               startScan;
	logic [31:0]        curEntry;
	logic               hit;
	logic [GAIN_W-1:0]  next_gain;
	logic [HPCF_W-1:0]  next_hpcf;
	logic [LEVEL_W-1:0] next_min;
	logic [LEVEL_W-1:0] next_minP;
	logic               wrEn;
	logic               addrPhase;

	// Bus decode
	assign addrPhase = hsel & htrans[1] & hready;
	assign wrEn      = dpValid & dpWrite;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			dpValid <= 1'b0;
			dpWrite <= 1'b0;
			dpAddr  <= 12'h000;
		end else if (hready) begin
			dpValid <= addrPhase;
			dpWrite <= hwrite;
			dpAddr  <= haddr[11:0];
		end
	end

	// Zero wait states; OKAY only
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	always_comb begin
		rdMux = 32'h0000_0000;
		if (haddr[11:2] < 10'(ARU_TABLE_DEPTH)) begin
			rdMux = table_q[haddr[6:2]];
		end else if (haddr[11:0] == ARU_SIZE_ADDR) begin
			rdMux = {24'h00_0000, tableSize};
		end else if (haddr[11:0] == ARU_RXCTRL_ADDR) begin
			rdMux[ARU_RX_GAIN_LSB +: GAIN_W]  = rxGain;
			rdMux[ARU_RECEIVER_HIGHPASS_CORNER_LSB +: HPCF_W]  = rxHpcf;
			rdMux[ARU_RX_MIN_LSB +: LEVEL_W]  = minLevel;
			rdMux[ARU_RX_MINP_LSB +: LEVEL_W] = minLevelP;
		end else if (haddr[11:0] == ARU_STATUS_ADDR) begin
			rdMux[ARU_ST_BUSY_BIT]       = (state != ARU_IDLE);
			rdMux[ARU_ST_HIT_BIT]        = lastHit;
			rdMux[ARU_ST_IDX_LSB +: 5]   = matchIdx;
			rdMux[ARU_ST_GEAR_LSB +: 4]  = dpcGear;
		end
	end

	// Read data launched at the address-phase edge
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdMux;
		end
	end

	// Table words and size byte, written by the configuration store
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < ARU_TABLE_DEPTH; i++) begin
				table_q[i] <= ARU_ENTRY_RST;
			end
			tableSize <= ARU_SIZE_RST;
		end else if (wrEn) begin
			if (dpAddr[11:2] < 10'(ARU_TABLE_DEPTH)) begin
				table_q[dpAddr[6:2]] <= hwdata;
			end else if (dpAddr == ARU_SIZE_ADDR) begin
				tableSize <= hwdata[7:0];
			end
		end
	end

	// Table bounds
	assign awcCount = tableSize[ARU_SZ_AWC_LSB +: 4];
	assign arcCount = tableSize[ARU_SZ_ARC_LSB +: 4];
	// Base moves with the shaping count, stale entries are software's problem
	assign endIdx    = {1'b0, awcCount} + {1'b0, arcCount};
	assign scanLimit = (endIdx > ARU_DEPTH5) ? ARU_DEPTH5 : endIdx;
	assign curEntry  = (scanIdx < ARU_DEPTH5) ? table_q[scanIdx] : 32'h0;

	// Gear or mode changes; events during a scan are held, not lost
	assign trigger = (dpcGear != gearPrev) | (modeSel != modePrev);
	assign startScan = (state == ARU_IDLE) && (trigger || pending) &&
		(arcCount != 4'h0) && ({1'b0, awcCount} < scanLimit);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			gearPrev <= 4'h0;
			modePrev <= 16'h0000;
			pending  <= 1'b0;
		end else begin
			gearPrev <= dpcGear;
			modePrev <= modeSel;
			if (trigger && state != ARU_IDLE) begin
				pending <= 1'b1;
			end else if (state == ARU_IDLE) begin
				pending <= 1'b0;
			end
		end
	end

	aru_entry_match u_match (
		.entry   (curEntry),
		.gear    (dpcGear),
		.modeSel (modeSel),
		.hit     (hit)
	);

	// First match in table order wins
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			state    <= ARU_IDLE;
			scanIdx  <= 5'h00;
			matchIdx <= 5'h00;
			lastHit  <= 1'b0;
		end else begin
			case (state)
				ARU_IDLE: begin
					if (startScan) begin
						state   <= ARU_SCAN;
						scanIdx <= {1'b0, awcCount};
					end
				end
				ARU_SCAN: begin
					if (hit) begin
						state    <= ARU_APPLY;
						matchIdx <= scanIdx;
						lastHit  <= 1'b1;
					end else if (scanIdx + 5'h01 >= scanLimit) begin
						state   <= ARU_IDLE;
						lastHit <= 1'b0;
					end else begin
						scanIdx <= scanIdx + 5'h01;
					end
				end
				ARU_APPLY: begin
					state <= ARU_IDLE;
				end
				default: begin
					state <= ARU_IDLE;
				end
			endcase
		end
	end

	aru_sat_adj #(.W(GAIN_W)) u_gain (
		.base   (rxGain),
		.delta  (curEntry[ARU_F_GAIN_LSB +: ARU_DELTA_W]),
		.result (next_gain)
	);

	aru_sat_adj #(.W(HPCF_W)) u_hpcf (
		.base   (rxHpcf),
		.delta  (curEntry[ARU_F_HPCF_LSB +: ARU_DELTA_W]),
		.result (next_hpcf)
	);

	aru_sat_adj #(.W(LEVEL_W)) u_min (
		.base   (minLevel),
		.delta  (curEntry[ARU_F_MIN_LSB +: ARU_DELTA_W]),
		.result (next_min)
	);

	aru_sat_adj #(.W(LEVEL_W)) u_minp (
		.base   (minLevelP),
		.delta  (curEntry[ARU_F_MINP_LSB +: ARU_DELTA_W]),
		.result (next_minP)
	);

	// Applied entry beats a same-cycle protocol-load write
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rxGain    <= '0;
			rxHpcf    <= '0;
			minLevel  <= '0;
			minLevelP <= '0;
		end else if (state == ARU_APPLY) begin
			rxGain    <= next_gain;
			rxHpcf    <= next_hpcf;
			minLevel  <= next_min;
			minLevelP <= next_minP;
		end else if (wrEn && dpAddr == ARU_RXCTRL_ADDR) begin
			rxGain    <= hwdata[ARU_RX_GAIN_LSB +: GAIN_W];
			rxHpcf    <= hwdata[ARU_RECEIVER_HIGHPASS_CORNER_LSB +: HPCF_W];
			minLevel  <= hwdata[ARU_RX_MIN_LSB +: LEVEL_W];
			minLevelP <= hwdata[ARU_RX_MINP_LSB +: LEVEL_W];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			scanBusy <= 1'b0;
		end else begin
			scanBusy <= startScan || (state == ARU_SCAN && !hit &&
				scanIdx + 5'h01 < scanLimit) || (state == ARU_SCAN && hit);
		end
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	sequence seqStart;
		state == ARU_IDLE && startScan;
	endsequence

	sequence seqHit;
		state == ARU_SCAN && hit;
	endsequence

	sequence seqMiss;
		state == ARU_SCAN && !hit && scanIdx + 5'h01 >= scanLimit;
	endsequence

	AST_ZERO_OFF: assert property (
		state == ARU_IDLE && arcCount == 4'h0 |=> state == ARU_IDLE)
		else $error("scan started with zero receiver entries");

	AST_BASE: assert property (
		seqStart |=> state == ARU_SCAN && scanIdx == {1'b0, $past(awcCount)})
		else $error("scan did not start after shaping entries");

	AST_GEAR_TRIG: assert property (
		state == ARU_IDLE && dpcGear != gearPrev && arcCount != 4'h0 &&
		{1'b0, awcCount} < scanLimit |=> state == ARU_SCAN)
		else $error("gear change did not start a search");

	AST_MISS_KEEP: assert property (
		seqMiss ##0 !(wrEn && dpAddr == ARU_RXCTRL_ADDR) |=>
		state == ARU_IDLE && $stable(rxGain) && $stable(rxHpcf) &&
		$stable(minLevel) && $stable(minLevelP))
		else $error("receiver settings changed without a match");

	AST_FIRST: assert property (
		seqHit |=> state == ARU_APPLY && matchIdx == $past(scanIdx)
		##1 state == ARU_IDLE)
		else $error("match not applied from first hit");

	AST_GEAR_EQ: assert property (
		state == ARU_APPLY |->
		$past(curEntry[ARU_F_GEAR_LSB +: 4]) == $past(dpcGear) &&
		|($past(curEntry[ARU_F_MASK_LSB +: 16]) & $past(modeSel)))
		else $error("applied entry does not match gear and mode");

	AST_GAIN_UP: assert property (
		state == ARU_APPLY && !curEntry[9] && curEntry[8:7] != 2'b00 &&
		rxGain != {GAIN_W{1'b1}} |=> rxGain > $past(rxGain))
		else $error("positive gain change not applied");

	AST_HPCF_DN: assert property (
		state == ARU_APPLY && curEntry[6] && curEntry[5:4] != 2'b00 &&
		rxHpcf != '0 |=> rxHpcf < $past(rxHpcf))
		else $error("negative corner change not applied");

	AST_MINP_ZERO: assert property (
		state == ARU_APPLY && curEntry[14:13] == 2'b00 |=> $stable(minLevelP))
		else $error("zero floor change altered the value");

	AST_OVERRIDE: assert property (
		state == ARU_APPLY && wrEn && dpAddr == ARU_RXCTRL_ADDR
		|=> minLevel == $past(next_min))
		else $error("protocol-load write beat the applied entry");

	AST_SCAN_END: assert property (
		seqStart |=> ##[1:21] state == ARU_IDLE)
		else $error("scan did not finish within the table");

endmodule // aru_receiver_lut

/* aru_sat_adj.sv */
`timescale 1ns/100ps
module aru_sat_adj
	import aru_pkg::*;
#(
	parameter int W = 2
) (
	// Current field and sign-magnitude delta
	input  wire logic [W-1:0]           base,
	input  wire logic [ARU_DELTA_W-1:0] delta,
	// Clamped result
	output logic      [W-1:0]           result
);

	localparam logic [W+1:0] MAXV = {2'b00, {W{1'b1}}};

	logic [W+1:0] ext;
	logic [W+1:0] mag;
	logic [W+1:0] sum;

	always_comb begin
		ext = {2'b00, base};
		mag = {{W{1'b0}}, delta[ARU_DELTA_W-2:0]};
		sum = ext + mag;
		if (delta[ARU_DELTA_W-1]) begin
			// Clamp at zero rather than wrap
			result = (ext < mag) ? '0 : W'(ext - mag);
		end else begin
			result = (sum > MAXV) ? {W{1'b1}} : sum[W-1:0];
		end
	end

endmodule // aru_sat_adj

/* tb_top.sv */
`timescale 1ns/100ps
module tb_top
	import aru_pkg::*;
;
	logic        clock;
	logic        arst_n;
	logic        hsel;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [3:0]  reqGear;
	logic [3:0]  dpcGear;
	logic [15:0] reqMode;
	logic [15:0] modeSel;
	logic [1:0]  rxGain;
	logic [1:0]  rxHpcf;
	logic [3:0]  minLevel;
	logic [3:0]  minLevelP;
	logic        scanBusy;
	logic [31:0] rd;
	logic [31:0] tbl [5];
	int          fail_count;
	int          compares;

	aru_receiver_lut DUT (
		.clock(clock), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .dpcGear(dpcGear),
		.modeSel(modeSel), .rxGain(rxGain), .rxHpcf(rxHpcf),
		.minLevel(minLevel), .minLevelP(minLevelP), .scanBusy(scanBusy)
	);

	aru_gear_src farSide (
		.clock(clock), .arst_n(arst_n), .reqGear(reqGear),
		.reqMode(reqMode), .dpcGear(dpcGear), .modeSel(modeSel)
	);

	always #12.5 clock = ~clock;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("Compares %0d, mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task waitReady;
		int n;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			fail_count++;
			tally_and_finish;
		end
	endtask

	task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hwrite <= w;
		haddr  <= {20'h00000, a};
		htrans <= 2'h2;
		waitReady;
		htrans <= 2'h0;
		hwdata <= d;
		waitReady;
		rd = hrdata;
	endtask

	task rdChk(input logic [11:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	// Busy flag must show within a short bound exactly when b is set, then the scan must end
	task gear(input logic [3:0] g, input logic [15:0] m, input logic b);
		int n;
		logic seen;
		reqGear <= g;
		reqMode <= m;
		n = 0;
		seen = 1'b0;
		do begin
			@(posedge clock);
			n++;
			if (scanBusy === 1'b1)
				seen = 1'b1;
		end while ((!seen && n < 20) || (seen && scanBusy !== 1'b0 && n < 60));
		if (scanBusy !== 1'b0) begin
			fail_count++;
			tally_and_finish;
		end
		@(posedge clock);
		check({31'h0, seen}, {31'h0, b});
	endtask

	function automatic logic [31:0] rxOut();
		return {20'h00000, minLevelP, minLevel, rxHpcf, rxGain};
	endfunction

	initial begin
		clock = 1'b0;
		arst_n = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		reqGear = 4'h0;
		reqMode = 16'h0001;
		fail_count = 0;
		compares = 0;
		// Index 0 and 1 are shaping words that would match if misplaced
		tbl = '{32'h0001_0183, 32'h0001_0183, 32'h0010_0183,
			32'h0001_CCD3, 32'h0001_EDF5};
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		check(rxOut(), 32'h0000_0000);
		rdChk(ARU_SIZE_ADDR, 32'h0000_0000);
		rdChk(12'h200, 32'h0000_0000);
		for (int i = 0; i < 5; i++)
			bus(1'b1, ARU_TBL_BASE + 12'(4 * i), tbl[i]);
		bus(1'b1, 12'h200, 32'hFFFF_FFFF);
		rdChk(12'h200, 32'h0000_0000);
		bus(1'b1, ARU_RXCTRL_ADDR, 32'h0000_8521);
		rdChk(ARU_RXCTRL_ADDR, 32'h0000_8521);
		// Receiver count zero
		bus(1'b1, ARU_SIZE_ADDR, 32'h0000_0002);
		gear(4'h3, 16'h0001, 1'b0);
		check(rxOut(), 32'h0000_0859);
		gear(4'h0, 16'h0001, 1'b0);
		// Two shaping words, three receiver words
		bus(1'b1, ARU_SIZE_ADDR, 32'h0000_0032);
		rdChk(ARU_SIZE_ADDR, 32'h0000_0032);
		gear(4'h3, 16'h0001, 1'b1);
		check(rxOut(), 32'h0000_0686);
		rdChk(ARU_STATUS_ADDR, 32'h0003_0302);
		// Every field pushed past its limit
		bus(1'b1, ARU_RXCTRL_ADDR, 32'h0000_0F03);
		gear(4'h5, 16'h0001, 1'b1);
		check(rxOut(), 32'h0000_00F3);
		rdChk(ARU_STATUS_ADDR, 32'h0005_0402);
		gear(4'h7, 16'h0001, 1'b1);
		check(rxOut(), 32'h0000_00F3);
		bus(1'b0, ARU_STATUS_ADDR, 32'h0000_0000);
		check(rd & 32'h0000_0002, 32'h0000_0000);
		bus(1'b1, ARU_RXCTRL_ADDR, 32'h0000_0000);
		gear(4'h3, 16'h0001, 1'b1);
		check(rxOut(), 32'h0000_0031);
		// Mode change alone starts a new search
		gear(4'h3, 16'h0010, 1'b1);
		check(rxOut(), 32'h0000_0033);
		rdChk(ARU_STATUS_ADDR, 32'h0003_0202);
		// Write timed to land in the apply cycle; the entry must win
		reqMode <= 16'h0001;
		repeat (3) @(posedge clock);
		bus(1'b1, ARU_RXCTRL_ADDR, 32'h0000_0000);
		@(posedge clock);
		check(rxOut(), 32'h0000_0063);
		check({31'h0, hresp}, 32'h0000_0000);
		tally_and_finish;
	end
endmodule // tb_top
